/* shared/pma_pcs_pkg.sv */
// constants shared by the transceiver management register block
package pma_pcs_pkg;

   // bus geometry
   localparam int AXI_AW = 32;
   localparam int AXI_DW = 32;
   localparam int REG_W = 16;
   localparam int ADDR_LSB = 2;
   localparam int IDX_W = 12;
   localparam int IDX_MSB = ADDR_LSB + IDX_W - 1;

   // management-device nibble carried in printed offsets, stripped before access
   localparam logic [3:0] MMD_PMA = 4'h1;
   localparam logic [3:0] MMD_PCS = 4'h3;

   // printed offsets, device nibble included
   localparam logic [15:0] OFS_ABIL_RX_STATE = 16'h18F7;
   localparam logic [15:0] OFS_TEST_SELECT = 16'h18F8;
   localparam logic [15:0] OFS_RST_LOOP = 16'h3000;
   localparam logic [15:0] OFS_RST_LOOP_ALT = 16'h38E6;
   localparam logic [15:0] OFS_PCS_STATE = 16'h38E7;

   // register indices after stripping; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_ABIL_RX_STATE = OFS_ABIL_RX_STATE[IDX_W-1:0];
   localparam logic [IDX_W-1:0] IDX_TEST_SELECT = OFS_TEST_SELECT[IDX_W-1:0];
   localparam logic [IDX_W-1:0] IDX_RST_LOOP = OFS_RST_LOOP[IDX_W-1:0];
   localparam logic [IDX_W-1:0] IDX_RST_LOOP_ALT = OFS_RST_LOOP_ALT[IDX_W-1:0];
   localparam logic [IDX_W-1:0] IDX_PCS_STATE = OFS_PCS_STATE[IDX_W-1:0];
   localparam logic [IDX_W-1:0] IDX_INT_STATUS = 12'h900;
   localparam logic [IDX_W-1:0] IDX_INT_ENABLE = 12'h901;
   localparam logic [IDX_W-1:0] IDX_INT_CLEAR = 12'h902;

   // pma ability and receive state fields
   localparam int BIT_LOOP_ABIL = 13;
   localparam int BIT_TXLVL_ABIL = 12;
   localparam int BIT_LOWPWR_ABIL = 11;
   localparam int BIT_EEE_ABIL = 10;
   localparam int BIT_RXFLT_ABIL = 9;
   localparam int BIT_RX_POL = 2;
   localparam int BIT_RX_FAULT = 1;
   localparam int BIT_RX_LINK = 0;
   localparam logic LOOP_ABIL_VAL = 1'h1;
   localparam logic TXLVL_ABIL_VAL = 1'h1;
   localparam logic LOWPWR_ABIL_VAL = 1'h0;
   localparam logic EEE_ABIL_VAL = 1'h0;
   localparam logic RXFLT_ABIL_VAL = 1'h0;
   localparam logic [REG_W-1:0] ABIL_RX_STATE_RESET = 16'h3000;

   // transmit test selector
   localparam int TM_MSB = 15;
   localparam int TM_LSB = 13;
   localparam logic [2:0] TM_NORMAL = 3'h0;
   localparam logic [2:0] TM_MODE1 = 3'h1;
   localparam logic [2:0] TM_MODE2 = 3'h2;
   localparam logic [2:0] TM_MODE3 = 3'h3;
   localparam logic [2:0] TM_ACT_NONE = 3'h0;
   localparam logic [2:0] TM_ACT_1 = 3'h1;
   localparam logic [2:0] TM_ACT_2 = 3'h2;
   localparam logic [2:0] TM_ACT_3 = 3'h4;

   // coding layer control fields
   localparam int BIT_PCS_RST = 15;
   localparam int BIT_PCS_LOOP = 14;

   // interrupt status layout
   localparam int INT_W = 3;
   localparam int INT_FAULT = 0;
   localparam int INT_LINK_DOWN = 1;
   localparam int INT_RST_DONE = 2;

   // byte lanes
   localparam int LANE_LO = 0;
   localparam int LANE_HI = 1;

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : pma_pcs_pkg

/* verilog/sync_2ff.sv */
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none

module sync_2ff #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   logic [W-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         meta <= '0;
         dout <= '0;
      end
      else
      begin
         meta <= din;
         dout <= meta;
      end
   end

endmodule : sync_2ff

`default_nettype wire

/* verilog/sticky_flags.sv */
// sticky flags, hardware set beats software clear
`timescale 1ns/1ns
`default_nettype none

module sticky_flags #(
   parameter int W = 1
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic [W-1:0] set,
   input wire logic [W-1:0] clr,
   output logic [W-1:0] flags
);

   // set wins over clear in the same cycle
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         flags <= '0;
      else
         flags <= set | (flags & ~clr);
   end

endmodule : sticky_flags

`default_nettype wire

/* verilog/pma_pcs_link_lpi_state_control_regs.sv */
// pma and pcs management registers behind an axi4-lite slave
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

module pma_pcs_link_lpi_state_control_regs
   import pma_pcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   // axi4-lite write address
   input wire logic [AXI_AW-1:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic awvalid,
   output logic awready,
   // axi4-lite write data
   input wire logic [AXI_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   // axi4-lite write response
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // axi4-lite read address
   input wire logic [AXI_AW-1:0] araddr,
   input wire logic [2:0] arprot,
   input wire logic arvalid,
   output logic arready,
   // axi4-lite read data
   output logic [AXI_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // receive path status pins
   input wire logic rxPolarityInv,
   input wire logic rxFaultDetect,
   input wire logic rxLinkUp,
   // coding layer handshake
   input wire logic codingLayerResetDone,
   // controls to the datapath
   output logic codingLayerSoftReset,
   output logic codingLayerLoopEnable,
   output logic [2:0] testModeSel,
   output logic [2:0] testModeActive,
   output logic irq
);

   // synchronised pin levels
   logic rxPolS;
   logic rxFaultS;
   logic rxLinkS;
   logic rxFaultD;
   logic rxLinkD;

   // write channel holding state
   logic awHeld;
   logic [AXI_AW-1:0] awAddrHeld;
   logic wHeld;
   logic [AXI_DW-1:0] wDataHeld;
   logic [3:0] wStrbHeld;
   logic doWrite;

   // write decode
   logic [IDX_W-1:0] wIdx;
   logic wInRange;
   logic wrLo;
   logic wrHi;
   logic wrAbilRxState;
   logic wrTestSel;
   logic wrRstLoop;
   logic wrIntEnable;
   logic wrIntClear;
   logic wMapped;

   // register state
   logic faultLatched;
   logic linkBit;
   logic faultClr;
   logic linkReload;
   logic [2:0] testMode;
   logic [INT_W-1:0] intStatus;
   logic [INT_W-1:0] intEnable;
   logic [INT_W-1:0] intSet;
   logic [INT_W-1:0] intClr;
   logic resetDoneEvt;

   // read decode
   logic [IDX_W-1:0] rIdx;
   logic rInRange;
   logic [REG_W-1:0] next_rdValue;
   logic next_rdMapped;
   logic [REG_W-1:0] abilRxStateValue;
   logic [REG_W-1:0] testSelValue;
   logic [REG_W-1:0] rstLoopValue;

   // pin levels cross into the management clock
   sync_2ff #(
      .W(3)
   ) u_pinSync (
      .mclk(mclk),
      .rstn(rstn),
      .din({rxPolarityInv, rxFaultDetect, rxLinkUp}),
      .dout({rxPolS, rxFaultS, rxLinkS})
   );

   // delayed copies for edge events
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         rxFaultD <= 1'h0;
         rxLinkD <= 1'h0;
      end
      else
      begin
         rxFaultD <= rxFaultS;
         rxLinkD <= rxLinkS;
      end
   end

   // a channel is accepted only while its holding slot is free
   assign awready = !awHeld && !bvalid;
   assign wready = !wHeld && !bvalid;
   assign doWrite = awHeld && wHeld && !bvalid;

   // write address capture
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         awHeld <= 1'h0;
         awAddrHeld <= '0;
      end
      else if (awvalid && awready)
      begin
         awHeld <= 1'h1;
         awAddrHeld <= awaddr;
      end
      else if (doWrite)
         awHeld <= 1'h0;
   end

   // write data capture
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         wHeld <= 1'h0;
         wDataHeld <= '0;
         wStrbHeld <= '0;
      end
      else if (wvalid && wready)
      begin
         wHeld <= 1'h1;
         wDataHeld <= wdata;
         wStrbHeld <= wstrb;
      end
      else if (doWrite)
         wHeld <= 1'h0;
   end

   // stripped offset decode for writes
   assign wIdx = awAddrHeld[IDX_MSB:ADDR_LSB];
   assign wInRange = (awAddrHeld[AXI_AW-1:IDX_MSB+1] == '0);
   assign wrLo = doWrite && wInRange && wStrbHeld[LANE_LO];
   assign wrHi = doWrite && wInRange && wStrbHeld[LANE_HI];
   assign wrAbilRxState = (wIdx == IDX_ABIL_RX_STATE);
   assign wrTestSel = (wIdx == IDX_TEST_SELECT);
   assign wrRstLoop = (wIdx == IDX_RST_LOOP) || (wIdx == IDX_RST_LOOP_ALT);
   assign wrIntEnable = (wIdx == IDX_INT_ENABLE);
   assign wrIntClear = (wIdx == IDX_INT_CLEAR);
   assign wMapped = wInRange && (wrAbilRxState || wrTestSel || wrRstLoop || wrIntEnable
                    || wrIntClear || (wIdx == IDX_INT_STATUS) || (wIdx == IDX_PCS_STATE));

   // write response
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         bvalid <= 1'h0;
         bresp <= RESP_OKAY;
      end
      else if (doWrite)
      begin
         bvalid <= 1'h1;
         bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
         bvalid <= 1'h0;
   end

   // zero writes to the latched receive bits
   assign faultClr = wrLo && wrAbilRxState && !wDataHeld[BIT_RX_FAULT];
   assign linkReload = wrLo && wrAbilRxState && !wDataHeld[BIT_RX_LINK];

   // receive fault latch, new fault beats the clear
   sticky_flags #(
      .W(1)
   ) u_faultLatch (
      .mclk(mclk),
      .rstn(rstn),
      .set(rxFaultS),
      .clr(faultClr),
      .flags(faultLatched)
   );

   // link bit drops with the link, a zero write re-arms it
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         linkBit <= 1'h0;
      else if (!rxLinkS)
         linkBit <= 1'h0;
      else if (linkReload)
         linkBit <= rxLinkS;
   end

   // transmit test selector, upper lane only
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         testMode <= TM_NORMAL;
      else if (wrHi && wrTestSel)
         testMode <= wDataHeld[TM_MSB:TM_LSB];
   end

   // test mode decode, reserved codes select nothing
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         testModeActive <= TM_ACT_NONE;
      else
      begin
         unique case (testMode)
            TM_MODE1: testModeActive <= TM_ACT_1;
            TM_MODE2: testModeActive <= TM_ACT_2;
            TM_MODE3: testModeActive <= TM_ACT_3;
            default: testModeActive <= TM_ACT_NONE;
         endcase
      end
   end

   assign testModeSel = testMode;

   // coding layer soft reset, request beats completion
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         codingLayerSoftReset <= 1'h0;
      else if (wrHi && wrRstLoop && wDataHeld[BIT_PCS_RST])
         codingLayerSoftReset <= 1'h1;
      else if (codingLayerResetDone)
         codingLayerSoftReset <= 1'h0;
   end

   // coding layer loopback enable
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         codingLayerLoopEnable <= 1'h0;
      else if (wrHi && wrRstLoop)
         codingLayerLoopEnable <= wDataHeld[BIT_PCS_LOOP];
   end

   // interrupt events
   assign resetDoneEvt = codingLayerSoftReset && codingLayerResetDone;
   always_comb
   begin
      intSet = '0;
      intSet[INT_FAULT] = rxFaultS && !rxFaultD;
      intSet[INT_LINK_DOWN] = rxLinkD && !rxLinkS;
      intSet[INT_RST_DONE] = resetDoneEvt;
   end

   assign intClr = (wrLo && wrIntClear) ? wDataHeld[INT_W-1:0] : '0;

   // interrupt status, set beats write-one clear
   sticky_flags #(
      .W(INT_W)
   ) u_intStatus (
      .mclk(mclk),
      .rstn(rstn),
      .set(intSet),
      .clr(intClr),
      .flags(intStatus)
   );

   // interrupt enable
   always_ff @(posedge mclk)
   begin
      if (!rstn)
         intEnable <= '0;
      else if (wrLo && wrIntEnable)
         intEnable <= wDataHeld[INT_W-1:0];
   end

   assign irq = |(intStatus & intEnable);

   // pma_ability_and_rx_state image, fixed abilities plus live state
   always_comb
   begin
      abilRxStateValue = '0;
      abilRxStateValue[BIT_LOOP_ABIL] = LOOP_ABIL_VAL;
      abilRxStateValue[BIT_TXLVL_ABIL] = TXLVL_ABIL_VAL;
      abilRxStateValue[BIT_LOWPWR_ABIL] = LOWPWR_ABIL_VAL;
      abilRxStateValue[BIT_EEE_ABIL] = EEE_ABIL_VAL;
      abilRxStateValue[BIT_RXFLT_ABIL] = RXFLT_ABIL_VAL;
      abilRxStateValue[BIT_RX_POL] = rxPolS;
      abilRxStateValue[BIT_RX_FAULT] = faultLatched;
      abilRxStateValue[BIT_RX_LINK] = linkBit;
   end

   // control register images
   always_comb
   begin
      testSelValue = '0;
      testSelValue[TM_MSB:TM_LSB] = testMode;
      rstLoopValue = '0;
      rstLoopValue[BIT_PCS_RST] = codingLayerSoftReset;
      rstLoopValue[BIT_PCS_LOOP] = codingLayerLoopEnable;
   end

   // stripped offset decode for reads
   assign rIdx = araddr[IDX_MSB:ADDR_LSB];
   assign rInRange = (araddr[AXI_AW-1:IDX_MSB+1] == '0);

   // read mux
   always_comb
   begin
      next_rdValue = '0;
      next_rdMapped = 1'h1;
      if (!rInRange)
         next_rdMapped = 1'h0;
      else if (rIdx == IDX_ABIL_RX_STATE)
         next_rdValue = abilRxStateValue;
      else if (rIdx == IDX_TEST_SELECT)
         next_rdValue = testSelValue;
      else if ((rIdx == IDX_RST_LOOP) || (rIdx == IDX_RST_LOOP_ALT))
         next_rdValue = rstLoopValue;
      else if (rIdx == IDX_PCS_STATE)
         next_rdValue = '0;
      else if (rIdx == IDX_INT_STATUS)
         next_rdValue[INT_W-1:0] = intStatus;
      else if (rIdx == IDX_INT_ENABLE)
         next_rdValue[INT_W-1:0] = intEnable;
      else if (rIdx == IDX_INT_CLEAR)
         next_rdValue = '0;
      else
         next_rdMapped = 1'h0;
   end

   assign arready = !rvalid;

   // read response
   always_ff @(posedge mclk)
   begin
      if (!rstn)
      begin
         rvalid <= 1'h0;
         rdata <= '0;
         rresp <= RESP_OKAY;
      end
      else if (arvalid && arready)
      begin
         rvalid <= 1'h1;
         rdata <= {{(AXI_DW-REG_W){1'h0}}, next_rdValue};
         rresp <= next_rdMapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
         rvalid <= 1'h0;
   end

endmodule : pma_pcs_link_lpi_state_control_regs

`default_nettype wire

/* verif/pma_pcs_link_lpi_state_control_regs_asserts.sv */
// assertion checker for the pma and pcs management register block
`timescale 1ns/1ns
`default_nettype none

module pma_pcs_link_lpi_state_control_regs_asserts
   import pma_pcs_pkg::*;
(
   input wire logic mclk,
   input wire logic rstn,
   input wire logic awready,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic [AXI_DW-1:0] rdata,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic codingLayerResetDone,
   input wire logic codingLayerSoftReset,
   input wire logic codingLayerLoopEnable,
   input wire logic [2:0] testModeSel,
   input wire logic [2:0] testModeActive
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // bus answers stand until taken
   a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_write_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while response pending");
   a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_rdata_upper: assert property (rvalid |-> rdata[31:16] == 16'h0)
      else $error("upper read bits not zero");
   // test selector decode, and update moment of test selector and loop enable
   a_mode_decode: assert property ($past(rstn) |-> testModeActive ==
      ($past(testModeSel) == TM_MODE1 ? TM_ACT_1 : $past(testModeSel) == TM_MODE2 ? TM_ACT_2 :
      $past(testModeSel) == TM_MODE3 ? TM_ACT_3 : TM_ACT_NONE))
      else $error("test mode decode wrong");
   a_mode_write: assert property ($past(rstn) && $changed(testModeSel) |-> $rose(bvalid))
      else $error("test field changed without write");
   a_loop_write: assert property ($past(rstn) && $changed(codingLayerLoopEnable) |->
      $rose(bvalid))
      else $error("loop enable changed without write");
   // soft reset request lifecycle
   a_rst_hold: assert property (codingLayerSoftReset && !codingLayerResetDone |=>
      codingLayerSoftReset)
      else $error("soft reset dropped early");
   a_rst_clear: assert property ($past(rstn) && $fell(codingLayerSoftReset) |->
      $past(codingLayerResetDone))
      else $error("soft reset cleared without done");
   a_rst_start: assert property ($past(rstn) && $rose(codingLayerSoftReset) |->
      $rose(bvalid))
      else $error("soft reset without write");
endmodule : pma_pcs_link_lpi_state_control_regs_asserts

bind pma_pcs_link_lpi_state_control_regs pma_pcs_link_lpi_state_control_regs_asserts
   pma_pcs_link_lpi_state_control_regs_asserts_i (.mclk(mclk), .rstn(rstn), .awready(awready),
   .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
   .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
   .codingLayerResetDone(codingLayerResetDone), .codingLayerSoftReset(codingLayerSoftReset),
   .codingLayerLoopEnable(codingLayerLoopEnable), .testModeSel(testModeSel),
   .testModeActive(testModeActive));

`default_nettype wire

/* verif/pma_pcs_link_lpi_state_control_regs_tb.sv */
// self-checking bench for the pma and pcs management register block
`timescale 1ns/1ns
`default_nettype none

module pma_pcs_link_lpi_state_control_regs_tb
   import pma_pcs_pkg::*;
;
   logic mclk = 1'b0, rstn = 1'b0;
   logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
   logic [AXI_DW-1:0] wdata = '0, rdata;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic rxPolarityInv = 1'h0, rxFaultDetect = 1'h0, rxLinkUp = 1'h0;
   logic codingLayerResetDone = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic codingLayerSoftReset, codingLayerLoopEnable;
   logic [1:0] bresp, rresp;
   logic [2:0] testModeSel, testModeActive;
   int miscompares = 0;
   int n_checks = 0;

   // free-running clock
   always #5 mclk = ~mclk;

   pma_pcs_link_lpi_state_control_regs pma_pcs_link_lpi_state_control_regs_i (.mclk(mclk), .rstn(rstn),
      .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
      .rxPolarityInv(rxPolarityInv), .rxFaultDetect(rxFaultDetect), .rxLinkUp(rxLinkUp),
      .codingLayerResetDone(codingLayerResetDone), .codingLayerSoftReset(codingLayerSoftReset),
      .codingLayerLoopEnable(codingLayerLoopEnable), .testModeSel(testModeSel),
      .testModeActive(testModeActive), .irq(irq));

   task automatic end_sim();
      if (miscompares == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         miscompares++;
         $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
      end
   endtask : chk

   function automatic logic [31:0] ba(input logic [IDX_W-1:0] i);
      return {18'h0, i, 2'h0};
   endfunction : ba

   task automatic cyc(input int k);
      repeat (k) @(posedge mclk);
   endtask : cyc

   // write: address and data offered together, each dropped when taken; hold delays bready
   task automatic axw(input logic [31:0] a, d, input logic [3:0] s, input logic [1:0] er,
      input int hold);
      logic ta, tw, tb;
      logic [1:0] r;
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= (hold == 0);
      do
      begin
         @(negedge mclk);
         n++;
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         r = bresp;
         @(posedge mclk);
         if (ta) awvalid <= 1'h0;
         if (tw) wvalid <= 1'h0;
         if (tb) bready <= 1'h0;
         else if (n == hold) bready <= 1'h1;
      end
      while (!tb);
      chk(32'(r), 32'(er));
   endtask : axw

   // read: one word, data taken with the answer; hold delays rready
   task automatic axr(input logic [31:0] a, exp, input logic [1:0] er, input int hold);
      logic ta, tb;
      logic [31:0] d;
      logic [1:0] r;
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= (hold == 0);
      do
      begin
         @(negedge mclk);
         n++;
         ta = arvalid && arready;
         tb = rvalid && rready;
         d = rdata;
         r = rresp;
         @(posedge mclk);
         if (ta) arvalid <= 1'h0;
         if (tb) rready <= 1'h0;
         else if (n == hold) rready <= 1'h1;
      end
      while (!tb);
      chk(d, exp);
      chk(32'(r), 32'(er));
   endtask : axr

   task automatic wr(input logic [IDX_W-1:0] i, input logic [31:0] d);
      axw(ba(i), d, 4'hF, RESP_OKAY, 0);
   endtask : wr

   task automatic rd(input logic [IDX_W-1:0] i, input logic [31:0] exp);
      axr(ba(i), exp, RESP_OKAY, 0);
   endtask : rd

   // hang guard
   initial
   begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      end_sim();
   end

   // main sequence
   initial
   begin
      repeat (4) @(posedge mclk);
      rstn <= 1'b1;
      rd(IDX_ABIL_RX_STATE, 32'h3000);
      rd(IDX_TEST_SELECT, 32'h0);
      rd(IDX_RST_LOOP, 32'h0);
      rd(IDX_RST_LOOP_ALT, 32'h0);
      rd(IDX_INT_STATUS, 32'h0);
      rxFaultDetect <= 1'h1;
      cyc(4);
      rxFaultDetect <= 1'h0;
      cyc(4);
      rd(IDX_ABIL_RX_STATE, 32'h3002);
      chk(32'(irq), 32'h0);
      wr(IDX_INT_ENABLE, 32'h7);
      chk(32'(irq), 32'h1);
      rd(IDX_INT_STATUS, 32'h1);
      wr(IDX_ABIL_RX_STATE, 32'h0);
      rd(IDX_ABIL_RX_STATE, 32'h3000);
      wr(IDX_INT_CLEAR, 32'h7);
      chk(32'(irq), 32'h0);
      rd(IDX_INT_CLEAR, 32'h0);
      rxLinkUp <= 1'h1;
      cyc(4);
      rd(IDX_ABIL_RX_STATE, 32'h3000);
      wr(IDX_ABIL_RX_STATE, 32'h0);
      rd(IDX_ABIL_RX_STATE, 32'h3001);
      rxLinkUp <= 1'h0;
      cyc(4);
      rd(IDX_ABIL_RX_STATE, 32'h3000);
      rd(IDX_INT_STATUS, 32'h2);
      chk(32'(irq), 32'h1);
      wr(IDX_INT_CLEAR, 32'h2);
      rxPolarityInv <= 1'h1;
      cyc(4);
      wr(IDX_ABIL_RX_STATE, 32'hFFFF);
      rd(IDX_ABIL_RX_STATE, 32'h3004);
      rxPolarityInv <= 1'h0;
      cyc(4);
      rd(IDX_ABIL_RX_STATE, 32'h3000);
      for (int c = 0; c < 8; c++)
      begin
         wr(IDX_TEST_SELECT, 32'(c) << TM_LSB);
         rd(IDX_TEST_SELECT, 32'(c) << TM_LSB);
         chk(32'(testModeSel), 32'(c));
         chk(32'(testModeActive), (c > 0 && c < 4) ? 32'(1 << (c - 1)) : 32'h0);
      end
      axw(ba(IDX_TEST_SELECT), 32'h0, 4'h1, RESP_OKAY, 3);
      rd(IDX_TEST_SELECT, 32'hE000);
      wr(IDX_TEST_SELECT, 32'hFFFF);
      rd(IDX_TEST_SELECT, 32'hE000);
      wr(IDX_RST_LOOP, 32'h8000);
      chk(32'(codingLayerSoftReset), 32'h1);
      rd(IDX_RST_LOOP_ALT, 32'h8000);
      codingLayerResetDone <= 1'h1;
      @(posedge mclk);
      codingLayerResetDone <= 1'h0;
      cyc(2);
      chk(32'(codingLayerSoftReset), 32'h0);
      rd(IDX_RST_LOOP, 32'h0);
      rd(IDX_INT_STATUS, 32'h4);
      wr(IDX_RST_LOOP_ALT, 32'h7FFF);
      rd(IDX_RST_LOOP, 32'h4000);
      chk(32'(codingLayerLoopEnable), 32'h1);
      wr(IDX_RST_LOOP, 32'h0);
      rd(IDX_RST_LOOP_ALT, 32'h0);
      chk(32'(codingLayerLoopEnable), 32'h0);
      axr(32'h63DC, 32'h0, RESP_SLVERR, 2);
      axw(32'hC000, 32'h4000, 4'hF, RESP_SLVERR, 0);
      rd(IDX_RST_LOOP, 32'h0);
      axr(ba(12'h100), 32'h0, RESP_SLVERR, 0);
      wr(IDX_PCS_STATE, 32'hFFFF);
      rd(IDX_PCS_STATE, 32'h0);
      end_sim();
   end
endmodule : pma_pcs_link_lpi_state_control_regs_tb

`default_nettype wire
